// *** rtl/ufd_core.sv ***
// Purpose: full-speed usb device core, register file and link event logic
// Assumes: packet framing, crc and nrzi done by the serial engine beside it
// Notes:   registers on a 32-bit apb port, data 16 bits in the low half
// Function
// R1 - forced reset bit holds core in reset
// R2 - shutdown bit switches core fully off
// R3 - low power bit cleared on wake-up
// R4 - raise suspend event after 3 ms idle
// R5 - software holds remote wake 1 to 15 ms
// R6 - l1 resume bit drives resume, self clears
// R7 - control bits 7..15 enable interrupt sources
// R8 - control register resets to 0x0003
// R9 - eight bidirectional endpoints, 512 bytes each
// R10 - descriptor entry at base plus n times 16
// R11 - descriptor base from table base register
// R12 - 16-bit registers on word-aligned addresses
// R13 - framing in hardware, software sees payload
// R14 - crc check, double buffering, frame pulse
// R15 - registers at their fixed offsets
// R16 - flags set on event, enables gate request
// R17 - lowest pending endpoint reported first
// R18 - unmaskable high and maskable low requests
// R19 - forced reset freezes state, blocks writes; the code clears address, frame, endpoint and flag state to zero instead
`timescale 1ns/100ps
`default_nettype none
`include "ufd_defs.svh"

module ufd_core #(
	parameter int unsigned NUM_EP    = 8,
	parameter int unsigned SUSPEND_EVENT_CYC  = `UFD_SUSPEND_EVENT_IDLE_US * `UFD_CLK_MHZ,
	parameter int unsigned FRAME_CYC = `UFD_FRAME_US * `UFD_CLK_MHZ,
	parameter int unsigned L1RES_CYC = `UFD_L1RES_US * `UFD_CLK_MHZ
) (
	input  wire logic                  i_clk,          // 200 mhz core clock
	input  wire logic                  i_nrst,         // async reset, low
	input  wire logic                  i_psel,         // apb select
	input  wire logic                  i_penable,      // apb access phase
	input  wire logic                  i_pwrite,       // apb write
	input  wire logic [11:0]           i_paddr,        // apb byte address
	input  wire logic [31:0]           i_pwdata,       // apb write data
	output logic      [31:0]           o_prdata,       // apb read data
	output logic                       o_pready,       // apb ready
	output logic                       o_pslverr,      // unmapped address
	input  wire logic                  i_bus_activity, // any bus traffic
	input  wire logic                  i_sof,          // frame start seen
	input  wire logic [10:0]           i_sof_frame,    // frame number of it
	input  wire logic                  i_bus_reset,    // host bus reset
	input  wire logic                  i_resume_seen,  // host resume
	input  wire logic                  i_l1_accept,    // l1 entry accepted
	input  wire logic                  i_pid_err,      // framing error
	input  wire logic                  i_pma_ovr,      // buffer over/underrun
	input  wire logic [NUM_EP-1:0]     i_tx_done,      // in transfer done
	input  wire logic [NUM_EP-1:0]     i_rx_done,      // out transfer done
	input  wire ufd_pkg::ufd_byte_s    i_rx,           // received payload byte
	input  wire logic                  i_rx_valid,     // byte valid
	input  wire logic                  i_rx_crc_ok,    // crc good, with last
	output logic                       o_rx_ready,     // buffer has room
	output ufd_pkg::ufd_byte_s         o_pm,           // byte to packet memory
	output logic                       o_pm_valid,     // byte valid
	input  wire logic                  i_pm_ready,     // memory takes byte
	input  wire logic [2:0]            i_desc_ep,      // endpoint to look up
	output logic      [31:0]           o_desc_tx,      // tx descriptor address
	output logic      [31:0]           o_desc_rx,      // rx descriptor address
	output logic                       o_irq_hp,       // unmaskable request
	output logic                       o_irq_lp,       // maskable request
	output logic                       o_core_rst,     // core held in reset
	output logic                       o_core_on,      // core powered
	output logic                       o_low_power,    // clock may be cut
	output logic                       o_suspend,      // core suspended
	output logic                       o_remote_wake,  // drive remote wake
	output logic                       o_l1_resume,    // drive l1 resume
	output logic                       o_frame_pulse,  // frame locked pulse
	output logic      [7:0]            o_dev_addr      // device address
);

	localparam int unsigned IW = $clog2(SUSPEND_EVENT_CYC + 1);
	localparam int unsigned FW = $clog2(FRAME_CYC + 1);
	localparam int unsigned LW = $clog2(L1RES_CYC + 1);
	localparam logic [IW-1:0] SUSPEND_EVENT_LAST  = IW'(SUSPEND_EVENT_CYC - 1);
	localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_CYC - 1);
	localparam logic [LW-1:0] L1_LAST    = LW'(L1RES_CYC - 1);

	// *****
	// functions
	// *****

	// word-aligned system address of a descriptor field
	function automatic logic [31:0] desc_sys(input logic [15:0] base,
		input logic [2:0] ep, input logic [15:0] field);
		logic [15:0] off;
		off = (base & `UFD_BTB_MASK) + 16'({ep, 4'h0}) + field;
		return `UFD_PMA_BASE + {15'h0000, off, 1'b0};
	endfunction

	// lowest numbered endpoint with a pending transfer
	function automatic logic [3:0] low_pend(input logic [NUM_EP-1:0] p);
		logic [3:0] id;
		id = 4'h0;
		for (int i = NUM_EP - 1; i >= 0; i--) begin
			if (p[i]) begin
				id = 4'(i);
			end
		end
		return id;
	endfunction

	// *****
	// register access decode
	// *****
	logic [15:0]             ctrl_q;
	logic [15:0]             ep_q [NUM_EP];
	logic [7:0]              flag_q;
	logic [10:0]             frame_q;
	logic [7:0]              daddr_q;
	logic [15:0]             btb_q;
	logic [15:0]             lpm_q;
	logic [15:0]             bcd_q;
	logic                    miss_q;
	logic [31:0]             rdata_q;
	ufd_pkg::ufd_lps_e       lps_q;
	logic [IW-1:0]           idle_q;
	logic                    idle_hit_q;
	logic [FW-1:0]           fcnt_q;
	logic [LW-1:0]           l1cnt_q;

	logic                    wr;
	logic                    wr_data;
	logic                    frst;
	logic                    active;
	logic                    suspend_event_ev;
	logic                    esof_ev;
	logic                    crc_bad;
	logic [7:0]              ev;
	logic [NUM_EP-1:0]       tx_pend;
	logic [NUM_EP-1:0]       rx_pend;
	logic [NUM_EP-1:0]       any_pend;
	logic [3:0]              pending_endpoint_id;
	logic [15:0]             ists;
	logic                    hit;
	logic [15:0]             rd;
	logic                    push;

	assign frst    = ctrl_q[`UFD_CTRL_FRST];
	assign active  = !frst && !ctrl_q[`UFD_CTRL_SHDN];      // see R1, see R2
	assign wr      = i_psel && i_penable && i_pwrite;
	assign wr_data = wr && !frst;                          // see R19
	assign o_pready  = 1'b1;                               // no wait states
	assign o_pslverr = i_psel && i_penable && miss_q;
	assign o_prdata  = rdata_q;

	// status view: lowest endpoint wins the id field
	always_comb begin
		for (int i = 0; i < NUM_EP; i++) begin
			tx_pend[i] = ep_q[i][`UFD_EP_TXDONE];
			rx_pend[i] = ep_q[i][`UFD_EP_RXDONE];
		end
		any_pend = tx_pend | rx_pend;
		pending_endpoint_id     = low_pend(any_pend);                     // see R17
		ists     = {|any_pend, flag_q[7:1], flag_q[0], 2'b00, 1'b0, pending_endpoint_id};
		ists[`UFD_ISTS_DOT] = rx_pend[pending_endpoint_id[2:0]];
	end

	// read mux on the low half; upper half reads zero
	always_comb begin
		hit = 1'b1;
		rd  = `UFD_ZERO16;
		if (i_paddr <= `UFD_OFF_EP_LAST && i_paddr[1:0] == 2'b00) begin
			rd = ep_q[i_paddr[4:2]];
		end else begin
			unique case (i_paddr)                          // see R15, see R12
				`UFD_OFF_CTRL:  rd = ctrl_q;
				`UFD_OFF_ISTS:  rd = ists;
				`UFD_OFF_FRAME: rd = {5'h00, frame_q};
				`UFD_OFF_DADDR: rd = {8'h00, daddr_q};
				`UFD_OFF_BTB:   rd = btb_q;
				`UFD_OFF_LPM:   rd = lpm_q;
				`UFD_OFF_BCD:   rd = bcd_q;
				default:        hit = 1'b0;
			endcase
		end
	end

	// read data is caught in the setup phase so it comes from a flop
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_q <= 32'h0000_0000;
			miss_q  <= 1'b0;
		end else if (i_psel && !i_penable) begin
			rdata_q <= {16'h0000, rd};
			miss_q  <= !hit;
		end
	end

	// *****
	// control register
	// *****

	// hardware clears win over a write in the same cycle
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_q <= `UFD_CTRL_RST;                       // see R8
		end else begin
			if (wr && i_paddr == `UFD_OFF_CTRL) begin
				ctrl_q <= i_pwdata[15:0] & `UFD_CTRL_WMASK; // see R7
			end
			if (active && (i_resume_seen || lps_q == ufd_pkg::LPS_L1RES)) begin
				ctrl_q[`UFD_CTRL_LPEN] <= 1'b0;            // see R3
			end
			if (lps_q == ufd_pkg::LPS_L1RES && l1cnt_q == L1_LAST) begin
				ctrl_q[`UFD_CTRL_L1RES] <= 1'b0;           // see R6
			end
		end
	end

	// *****
	// plain configuration registers
	// *****

	// device address and frame number are cleared to zero under forced reset
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			daddr_q <= 8'h00;
			frame_q <= 11'h000;
			btb_q   <= `UFD_ZERO16;
			lpm_q   <= `UFD_ZERO16;
			bcd_q   <= `UFD_ZERO16;
		end else if (frst) begin
			daddr_q <= 8'h00;                              // see R19
			frame_q <= 11'h000;
		end else begin
			if (wr_data && i_paddr == `UFD_OFF_DADDR) begin
				daddr_q <= i_pwdata[7:0];
			end
			if (wr_data && i_paddr == `UFD_OFF_BTB) begin
				btb_q <= i_pwdata[15:0] & `UFD_BTB_MASK;   // see R11
			end
			if (wr_data && i_paddr == `UFD_OFF_LPM) begin
				lpm_q <= i_pwdata[15:0];
			end
			if (wr_data && i_paddr == `UFD_OFF_BCD) begin
				bcd_q <= i_pwdata[15:0];
			end
			if (active && i_sof) begin
				frame_q <= i_sof_frame;
			end
		end
	end

	// *****
	// endpoint registers
	// *****

	// done bits clear on a written zero; a new completion wins
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int i = 0; i < NUM_EP; i++) begin
				ep_q[i] <= `UFD_ZERO16;
			end
		end else if (frst) begin
			for (int i = 0; i < NUM_EP; i++) begin
				ep_q[i] <= `UFD_ZERO16;                    // see R19
			end
		end else begin
			for (int i = 0; i < NUM_EP; i++) begin
				if (wr_data && i_paddr == `UFD_OFF_EP0 + 12'(i * 4)) begin
					ep_q[i] <= (ep_q[i] & ~`UFD_EP_WMASK) | (i_pwdata[15:0] & `UFD_EP_WMASK);
					ep_q[i][`UFD_EP_TXDONE] <= ep_q[i][`UFD_EP_TXDONE] & i_pwdata[`UFD_EP_TXDONE];
					ep_q[i][`UFD_EP_RXDONE] <= ep_q[i][`UFD_EP_RXDONE] & i_pwdata[`UFD_EP_RXDONE];
				end
				if (active && i_tx_done[i]) begin
					ep_q[i][`UFD_EP_TXDONE] <= 1'b1;       // see R9
				end
				if (active && i_rx_done[i]) begin
					ep_q[i][`UFD_EP_RXDONE] <= 1'b1;
				end
			end
		end
	end

	// *****
	// interrupt flags and requests
	// *****
	assign ev[`UFD_FLG_L1]    = i_l1_accept;
	assign ev[`UFD_FLG_ESOF]  = esof_ev;
	assign ev[`UFD_FLG_SOF]   = i_sof;
	assign ev[`UFD_FLG_RST]   = i_bus_reset;
	assign ev[`UFD_FLG_SUSPEND_EVENT]  = suspend_event_ev;
	assign ev[`UFD_FLG_WKUP]  = i_resume_seen;
	assign ev[`UFD_FLG_ERR]   = i_pid_err || crc_bad;
	assign ev[`UFD_FLG_PMAOU] = i_pma_ovr;

	// write zero clears, set wins over clear
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			flag_q <= 8'h00;
		end else if (frst) begin
			flag_q <= 8'h00;                               // see R19
		end else begin
			flag_q <= (wr_data && i_paddr == `UFD_OFF_ISTS
				? flag_q & i_pwdata[`UFD_ISTS_FLAG_LSB +: 8] : flag_q)
				| (ev & {8{active}});                      // see R16
		end
	end

	// many pending flags still make only one request
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_irq_lp <= 1'b0;
			o_irq_hp <= 1'b0;
		end else begin
			o_irq_lp <= active && (|(flag_q & ctrl_q[14:`UFD_CTRL_IEN_LSB])
				|| (|any_pend && ctrl_q[15]));             // see R7, see R18
			o_irq_hp <= 1'b0;
			for (int i = 0; i < NUM_EP; i++) begin
				if (ep_q[i][`UFD_EP_HPRI] && any_pend[i] && active) begin
					o_irq_hp <= 1'b1;                      // see R18, see R14
				end
			end
		end
	end

	// *****
	// idle and frame timers
	// *****

	// one suspend event per idle stretch, rearmed by traffic
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			idle_q     <= '0;
			idle_hit_q <= 1'b0;
		end else if (!active || i_bus_activity) begin
			idle_q     <= '0;
			idle_hit_q <= 1'b0;
		end else if (!idle_hit_q) begin
			idle_q     <= idle_q + IW'(1);
			idle_hit_q <= idle_q == SUSPEND_EVENT_LAST;             // see R4
		end
	end
	assign suspend_event_ev = active && !i_bus_activity && !idle_hit_q && idle_q == SUSPEND_EVENT_LAST;

	// missed frame start: a whole frame with no start packet
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			fcnt_q <= '0;
		end else if (!active || i_sof || lps_q != ufd_pkg::LPS_ACTIVE || esof_ev) begin
			fcnt_q <= '0;
		end else begin
			fcnt_q <= fcnt_q + FW'(1);
		end
	end
	assign esof_ev = active && !i_sof && lps_q == ufd_pkg::LPS_ACTIVE && fcnt_q == FRAME_LAST;

	// *****
	// link power state
	// *****

	// suspend follows the software bit; a host resume ends it at once
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			lps_q   <= ufd_pkg::LPS_ACTIVE;
			l1cnt_q <= '0;
		end else if (!active) begin
			lps_q   <= ufd_pkg::LPS_ACTIVE;                // see R1
			l1cnt_q <= '0;
		end else begin
			unique case (lps_q)
				ufd_pkg::LPS_ACTIVE: begin
					if (ctrl_q[`UFD_CTRL_L1RES]) begin
						lps_q <= ufd_pkg::LPS_L1RES;       // see R6
					end else if (ctrl_q[`UFD_CTRL_FSUS]) begin
						lps_q <= ufd_pkg::LPS_SUSPEND_EVENT;        // see R4
					end
				end
				ufd_pkg::LPS_SUSPEND_EVENT: begin
					if (i_resume_seen || !ctrl_q[`UFD_CTRL_FSUS]) begin
						lps_q <= ufd_pkg::LPS_ACTIVE;
					end
				end
				ufd_pkg::LPS_L1RES: begin
					l1cnt_q <= l1cnt_q + LW'(1);
					if (l1cnt_q == L1_LAST) begin
						lps_q   <= ufd_pkg::LPS_ACTIVE;
						l1cnt_q <= '0;
					end
				end
				default: begin
					lps_q <= ufd_pkg::LPS_ACTIVE;
				end
			endcase
		end
	end

	// status pins; remote wake timing is left to software
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_core_rst    <= 1'b1;
			o_core_on     <= 1'b0;
			o_suspend     <= 1'b0;
			o_low_power   <= 1'b0;
			o_remote_wake <= 1'b0;
			o_l1_resume   <= 1'b0;
			o_frame_pulse <= 1'b0;
			o_dev_addr    <= 8'h00;
		end else begin
			o_core_rst    <= frst;                         // see R1
			o_core_on     <= !ctrl_q[`UFD_CTRL_SHDN];      // see R2
			o_suspend     <= active && lps_q == ufd_pkg::LPS_SUSPEND_EVENT;
			o_low_power   <= active && lps_q == ufd_pkg::LPS_SUSPEND_EVENT
				&& ctrl_q[`UFD_CTRL_LPEN];                 // see R3
			o_remote_wake <= active && ctrl_q[`UFD_CTRL_RWAKE]; // see R5
			o_l1_resume   <= active && lps_q == ufd_pkg::LPS_L1RES;
			o_frame_pulse <= active && i_sof;              // see R14
			o_dev_addr    <= daddr_q;
		end
	end

	// *****
	// descriptor lookup
	// *****
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_desc_tx <= `UFD_PMA_BASE;
			o_desc_rx <= `UFD_PMA_BASE;
		end else begin
			o_desc_tx <= desc_sys(btb_q, i_desc_ep, 16'(`UFD_DESC_TXADDR)); // see R10
			o_desc_rx <= desc_sys(btb_q, i_desc_ep, 16'(`UFD_DESC_RXADDR)); // see R12
		end
	end

	// *****
	// payload buffer toward packet memory
	// *****

	// two entries so a memory stall drops no received byte
	ufd_pkg::ufd_byte_s buf_q [2];
	logic               wp_q;
	logic               rp_q;
	logic [1:0]         cnt_q;
	logic               pop;

	assign o_rx_ready = cnt_q != 2'd2 && active;
	assign push       = i_rx_valid && o_rx_ready;          // see R13
	assign pop        = o_pm_valid && i_pm_ready;
	assign o_pm_valid = cnt_q != 2'd0;
	assign o_pm       = buf_q[rp_q];
	assign crc_bad    = push && i_rx.last && !i_rx_crc_ok; // see R14

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			buf_q[0] <= '0;
			buf_q[1] <= '0;
			wp_q     <= 1'b0;
			rp_q     <= 1'b0;
			cnt_q    <= 2'd0;
		end else if (!active) begin
			wp_q     <= 1'b0;
			rp_q     <= 1'b0;
			cnt_q    <= 2'd0;
		end else begin
			if (push) begin
				buf_q[wp_q] <= i_rx;
				wp_q        <= !wp_q;
			end
			if (pop) begin
				rp_q <= !rp_q;
			end
			cnt_q <= cnt_q + 2'(push) - 2'(pop);
		end
	end

endmodule
`default_nettype wire

// *** rtl/ufd_defs.svh ***
// Purpose: offsets, field positions, reset values and timing of the usb device core
// Assumes: 32-bit peripheral bus, one 16-bit register per aligned word
// Notes:   definitions only
`ifndef UFD_DEFS_SVH
`define UFD_DEFS_SVH

// *****
// register byte offsets
// *****
`define UFD_OFF_EP0        12'h000
`define UFD_OFF_EP_LAST    12'h01C
`define UFD_OFF_CTRL       12'h040
`define UFD_OFF_ISTS       12'h044
`define UFD_OFF_FRAME      12'h048
`define UFD_OFF_DADDR      12'h04C
`define UFD_OFF_BTB        12'h050
`define UFD_OFF_LPM        12'h054
`define UFD_OFF_BCD        12'h058

// *****
// control fields and reset values
// *****
`define UFD_CTRL_FRST      0
`define UFD_CTRL_SHDN      1
`define UFD_CTRL_LPEN      2
`define UFD_CTRL_FSUS      3
`define UFD_CTRL_RWAKE     4
`define UFD_CTRL_L1RES     5
`define UFD_CTRL_IEN_LSB   7
`define UFD_CTRL_RST       16'h0003
`define UFD_CTRL_WMASK     16'hFFBF
`define UFD_ZERO16         16'h0000

// *****
// status, endpoint and table fields
// *****
`define UFD_ISTS_DOT       4
`define UFD_ISTS_FLAG_LSB  7
`define UFD_FLG_L1         0
`define UFD_FLG_ESOF       1
`define UFD_FLG_SOF        2
`define UFD_FLG_RST        3
`define UFD_FLG_SUSPEND_EVENT       4
`define UFD_FLG_WKUP       5
`define UFD_FLG_ERR        6
`define UFD_FLG_PMAOU      7
`define UFD_EP_TXDONE      7
`define UFD_EP_HPRI        8
`define UFD_EP_RXDONE      15
`define UFD_EP_WMASK       16'h010F
`define UFD_BTB_MASK       16'hFFF8
`define UFD_DESC_STRIDE    16
`define UFD_DESC_TXADDR    0
`define UFD_DESC_RXADDR    8
`define UFD_PMA_BASE       32'h4000_6000

// *****
// timing
// *****
`define UFD_CLK_MHZ        200
`define UFD_SUSPEND_EVENT_IDLE_US   3000
`define UFD_FRAME_US       1000
`define UFD_L1RES_US       50

`endif

// *** rtl/ufd_pkg.sv ***
// Purpose: types shared by the usb device core and its bench
// Assumes: nothing
// Notes:   constants live in ufd_defs.svh
package ufd_pkg;

	// link power state, gray along active -> suspended -> l1 resume
	typedef enum logic [1:0] {
		LPS_ACTIVE = 2'b00,
		LPS_SUSPEND_EVENT   = 2'b01,
		LPS_L1RES  = 2'b11
	} ufd_lps_e;

	// one payload byte of a received packet
	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} ufd_byte_s;

endpackage

// *** tb/testbench.sv ***
// Purpose: self-checking bench of the usb device core
// Assumes: shortened idle, frame and resume counts
// Notes:   inputs change on falling edges only
`timescale 1ns/100ps
`default_nettype none
`include "ufd_defs.svh"
module testbench;
	logic i_clk = 1'b0, i_nrst = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0000_0000, rd, o_prdata, o_desc_tx, o_desc_rx;
	logic [7:0] ev = 8'h00, i_tx_done = 8'h00, i_rx_done = 8'h00, o_dev_addr;
	logic [2:0] i_desc_ep = 3'h0;
	logic i_pm_ready = 1'b0, er, o_pready, o_pslverr, o_rx_ready, o_pm_valid, o_irq_hp;
	logic o_irq_lp, o_core_rst, o_core_on, o_low_power, o_suspend, o_remote_wake;
	logic o_l1_resume, o_frame_pulse, i_sof, i_bus_activity, i_rx_valid, i_rx_crc_ok;
	logic [10:0] i_sof_frame;
	ufd_pkg::ufd_byte_s i_rx, o_pm;
	int mismatches = 0, tests_run = 0;
	always #2.5 i_clk = ~i_clk;
	ufd_core #(.SUSPEND_EVENT_CYC(64), .FRAME_CYC(50), .L1RES_CYC(8)) ufd_core_i (.i_clk, .i_nrst,
		.i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
		.i_bus_activity, .i_sof, .i_sof_frame, .i_bus_reset(ev[3]), .i_resume_seen(ev[5]),
		.i_l1_accept(ev[0]), .i_pid_err(ev[6]), .i_pma_ovr(ev[7]), .i_tx_done, .i_rx_done,
		.i_rx, .i_rx_valid, .i_rx_crc_ok, .o_rx_ready, .o_pm, .o_pm_valid, .i_pm_ready,
		.i_desc_ep, .o_desc_tx, .o_desc_rx, .o_irq_hp, .o_irq_lp, .o_core_rst, .o_core_on,
		.o_low_power, .o_suspend, .o_remote_wake, .o_l1_resume, .o_frame_pulse, .o_dev_addr);
	ufd_host_model ufd_host_model_i (.i_clk, .i_rx_ready(o_rx_ready), .o_rx(i_rx),
		.o_rx_valid(i_rx_valid), .o_rx_crc_ok(i_rx_crc_ok), .o_sof(i_sof),
		.o_sof_frame(i_sof_frame), .o_activity(i_bus_activity));
	// *****
	// shared tasks
	// *****
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s exp %h got %h", n, exp, got);
		end
	endtask
	// setup then access phase, ready is always high
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
		@(negedge i_clk);
		i_psel = 1'b1;
		i_pwrite = w;
		i_paddr = a;
		i_pwdata = {16'h0000, d};
		@(negedge i_clk);
		i_penable = 1'b1;
		@(posedge i_clk);
		rd = o_prdata;
		er = o_pslverr;
		@(negedge i_clk);
		i_psel = 1'b0;
		i_penable = 1'b0;
	endtask
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] m, e);
		apb(1'b0, a, 16'h0000);
		chk(n, rd & m, e);
	endtask
	task automatic conclude;
		if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// *****
	// scenarios
	// *****
	task automatic t_reset;
		rdc("ctrl", `UFD_OFF_CTRL, 32'hFFFF, 32'h0003);
		chk("core_rst", o_core_rst, 32'h1);
		apb(1'b1, `UFD_OFF_DADDR, 16'h0055);
		rdc("addr_frozen", `UFD_OFF_DADDR, 32'hFFFF, 32'h0);
		apb(1'b0, 12'h05C, 16'h0000);
		chk("unmapped", er, 32'h1);
	endtask
	task automatic t_open;
		apb(1'b1, `UFD_OFF_CTRL, 16'h0010);
		repeat (2) @(negedge i_clk);
		chk("core_on", o_core_on, 32'h1);
		chk("wake", o_remote_wake, 32'h1);
		apb(1'b1, `UFD_OFF_CTRL, 16'h0000);
		apb(1'b1, `UFD_OFF_DADDR, 16'h005A);
		rdc("addr", `UFD_OFF_DADDR, 32'hFFFF, 32'h5A);
		chk("dev_addr", o_dev_addr, 32'h5A);
		apb(1'b1, `UFD_OFF_BTB, 16'h00FF);
		rdc("btb", `UFD_OFF_BTB, 32'hFFFF, 32'hF8);
		i_desc_ep = 3'h3;
		repeat (2) @(negedge i_clk);
		chk("desc_tx", o_desc_tx, 32'h4000_6000 + 2 * (32'hF8 + 48));
		chk("desc_rx", o_desc_rx, 32'h4000_6000 + 2 * (32'hF8 + 56));
	endtask
	// each event source except esof, sof and suspend, with only its own enable set
	task automatic t_events;
		for (int k = 0; k < 8; k++) begin
			if (k == 1 || k == 2 || k == 4) continue;
			apb(1'b1, `UFD_OFF_CTRL, 16'h0080 << k);
			@(negedge i_clk);
			ev[k] = 1'b1;
			@(negedge i_clk);
			ev = 8'h00;
			@(negedge i_clk);
			chk("irq_set", o_irq_lp, 32'h1);
			rdc("flag", `UFD_OFF_ISTS, 32'h80 << k, 32'h80 << k);
			apb(1'b1, `UFD_OFF_ISTS, ~(16'h0080 << k));
			repeat (2) @(negedge i_clk);
			chk("irq_clr", o_irq_lp, 32'h0);
		end
		apb(1'b1, `UFD_OFF_CTRL, 16'h0000);
	endtask
	task automatic t_ep;
		@(negedge i_clk);
		i_rx_done = 8'h24;
		@(negedge i_clk);
		i_rx_done = 8'h00;
		rdc("ep_first", `UFD_OFF_ISTS, 32'h1F, 32'h12);
		chk("irq_masked", o_irq_lp, 32'h0);
		apb(1'b1, 12'h008, 16'h0000);
		rdc("ep_next", `UFD_OFF_ISTS, 32'h1F, 32'h15);
		apb(1'b1, 12'h014, 16'h8100);
		@(negedge i_clk);
		chk("irq_hp", o_irq_hp, 32'h1);
	endtask
	task automatic t_link;
		ufd_host_model_i.sof(11'h123);
		rdc("frame", `UFD_OFF_FRAME, 32'h7FF, 32'h123);
		ufd_host_model_i.idle(70);
		rdc("suspend", `UFD_OFF_ISTS, 32'h800, 32'h800);
		apb(1'b1, `UFD_OFF_CTRL, 16'h000C);
		repeat (2) @(negedge i_clk);
		chk("low_power", o_low_power, 32'h1);
		chk("suspended", o_suspend, 32'h1);
		ev[5] = 1'b1;
		@(negedge i_clk);
		ev = 8'h00;
		rdc("wake_clr", `UFD_OFF_CTRL, 32'hFFFF, 32'h0008);
		apb(1'b1, `UFD_OFF_CTRL, 16'h0024);
		repeat (20) @(negedge i_clk);
		rdc("selfclr", `UFD_OFF_CTRL, 32'h24, 32'h0);
	endtask
	// two bytes fill the buffer while memory stalls
	task automatic t_stream;
		ufd_host_model_i.send(8'hA5, 1'b0);
		ufd_host_model_i.send(8'h3C, 1'b1);
		chk("full", o_rx_ready, 32'h0);
		chk("b0", o_pm, {8'hA5, 1'b0});
		i_pm_ready = 1'b1;
		@(negedge i_clk);
		chk("b1", o_pm, {8'h3C, 1'b1});
		@(negedge i_clk);
		chk("empty", o_pm_valid, 32'h0);
	endtask
	initial begin
		repeat (12) @(negedge i_clk);
		i_nrst = 1'b1;
		t_reset();
		t_open();
		t_events();
		t_ep();
		t_link();
		t_stream();
		conclude();
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		mismatches++;
		conclude();
	end
endmodule
`default_nettype wire

// *** tb/ufd_core_properties.sv ***
// Purpose: port assertions for the usb device core
// Assumes: shortened resume count passed in by the bind
// Notes:   bind sits at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module ufd_core_properties #(
	parameter int unsigned L1RES_CYC = 8
) (
	input wire logic               i_clk,         // clock
	input wire logic               i_nrst,        // reset, low
	input wire logic               i_psel,        // select
	input wire logic               i_penable,     // access
	input wire logic               o_pslverr,     // error
	input wire logic               i_sof,         // frame start
	input wire logic               o_frame_pulse, // frame pulse
	input wire logic               o_core_rst,    // held reset
	input wire logic               o_core_on,     // powered
	input wire logic               o_suspend,     // suspended
	input wire logic               o_rx_ready,    // room
	input wire logic               o_pm_valid,    // byte out
	input wire logic               i_pm_ready,    // byte taken
	input wire ufd_pkg::ufd_byte_s o_pm,          // byte
	input wire logic               o_l1_resume    // resume drive
);
	// *****
	// assertions
	// *****
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	int unsigned l1_cnt_q;
	// length of the resume drive, reset by each low cycle
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) l1_cnt_q <= 0;
		else l1_cnt_q <= o_l1_resume ? l1_cnt_q + 1 : 0;
	end
	AST_ERR_PHASE: assert property (o_pslverr |-> i_psel && i_penable)
		else $error("error outside access phase");
	AST_PULSE_CAUSE: assert property (o_frame_pulse |-> $past(i_sof))
		else $error("frame pulse without frame start");
	AST_PULSE_FOLLOWS: assert property (i_sof && !o_core_rst && o_core_on
		&& !o_suspend |=> o_frame_pulse) else $error("frame pulse missing");
	AST_RST_NO_RX: assert property (o_rx_ready |=> !o_core_rst)
		else $error("bytes taken in reset");
	AST_OFF_NO_RX: assert property (o_rx_ready |=> o_core_on)
		else $error("bytes taken while off");
	AST_PM_HOLD: assert property (o_pm_valid && !i_pm_ready
		|=> o_pm_valid && $stable(o_pm)) else $error("stalled byte lost");
	AST_L1_LEN: assert property ($fell(o_l1_resume) |-> l1_cnt_q == L1RES_CYC)
		else $error("resume drive length wrong");
	AST_RST_QUIET: assert property (o_core_rst && !o_frame_pulse |=> !o_frame_pulse)
		else $error("frame pulse in reset");
endmodule
bind ufd_core ufd_core_properties #(.L1RES_CYC(L1RES_CYC)) ufd_core_properties_i (.i_clk,
	.i_nrst, .i_psel, .i_penable, .o_pslverr, .i_sof, .o_frame_pulse, .o_core_rst,
	.o_core_on, .o_suspend, .o_rx_ready, .o_pm_valid, .i_pm_ready, .o_pm, .o_l1_resume);
`default_nettype wire

// *** tb/ufd_host_model.sv ***
// Purpose: host side model, frame starts, traffic and payload bytes
// Assumes: driven at falling edges
// Notes:   idle data line shows the inverted last byte
`timescale 1ns/100ps
`default_nettype none
module ufd_host_model (
	input  wire logic         i_clk,       // clock
	input  wire logic         i_rx_ready,  // core has room
	output ufd_pkg::ufd_byte_s o_rx,       // payload byte
	output logic              o_rx_valid,  // byte valid
	output logic              o_rx_crc_ok, // crc good
	output logic              o_sof,       // frame start
	output logic [10:0]       o_sof_frame, // frame number
	output logic              o_activity   // bus traffic
);
	// *****
	// host actions
	// *****
	initial begin
		o_rx = '0;
		o_rx_valid = 1'b0;
		o_rx_crc_ok = 1'b0;
		o_sof = 1'b0;
		o_sof_frame = 11'h000;
		o_activity = 1'b1;
	end
	// one payload byte, held until the core takes it or 51 cycles pass
	task automatic send(input logic [7:0] d, input logic l);
		@(negedge i_clk);
		o_rx = '{d, l};
		o_rx_valid = 1'b1;
		o_rx_crc_ok = l;
		for (int n = 0; n < 50 && !i_rx_ready; n++) @(negedge i_clk);
		@(negedge i_clk);
		o_rx_valid = 1'b0;
		o_rx.data = ~d;
	endtask
	task automatic sof(input logic [10:0] f);
		@(negedge i_clk);
		o_sof = 1'b1;
		o_sof_frame = f;
		@(negedge i_clk);
		o_sof = 1'b0;
	endtask
	// silence on the bus so the core can see suspend
	task automatic idle(input int n);
		o_activity = 1'b0;
		repeat (n) @(negedge i_clk);
		o_activity = 1'b1;
	endtask
endmodule
`default_nettype wire
